/* hw/crsm_map.v */
// Purpose: Data-memory decode: user RAM, control register window, stack.
// Assumes: CPU issues one byte access per cycle; stack ops sequenced by the CPU.
// Notes:   Read data is registered, one cycle after the request.
`timescale 1ns/100ps
`default_nettype none
`include "crsm_defs.vh"
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - 448 bytes of readable and writable RAM, stack included.
// - Control registers decode only in 0C0h through 0FFh.
// - Reserved control addresses read arbitrary data; writes do nothing defined.
// - Read/write registers accept bit and byte writes and read back.
// - Call or interrupt pushes return address before jumping.
// - Subroutine return restores PC; interrupt return restores PC and flags.
// - Pointer decrements after save, increments before restore.
// - Three port data registers, each followed by zero-reset direction register.
// - Watchdog control write-only, resets to 0Fh.
// - Port-1 function and edge select write-only zero; interrupt mode read/write.
// - Interrupt enable and request registers CCh-CFh read/write, reset zero.
// - Timer mode registers D0h-D2h and DAh read/write, reset zero.
// - Reload registers write-only; counts read back at shared addresses D5h, D9h and C7h, timer 1 count alone at D8h.
// - Standby selects read/write, release levels write-only, all reset zero.
// - Pull-up controls write-only at F8h-FAh, reset zero.
// - Open-drain registers read/write at DEh, DFh, E4h, reset zero.
// - Stack lives in page one; pointer not reset by hardware.
module crsm_map (
    input  wire                    clk,
    input  wire                    rst,
    input  wire                    req,
    input  wire                    wr,
    input  wire [`CRSM_AW-1:0]     addr,
    input  wire [`CRSM_DW-1:0]     wdata,
    input  wire                    sp_load,
    input  wire                    push,
    input  wire                    pop,
    input  wire [`CRSM_DW-1:0]     push_data,
    input  wire [`CRSM_DW-1:0]     p0_pins,
    input  wire [`CRSM_DW-1:0]     p1_pins,
    input  wire [`CRSM_DW-1:0]     p2_pins,
    input  wire [`CRSM_DW-1:0]     t0_hm_count,
    input  wire [`CRSM_DW-1:0]     t1_l_count,
    input  wire [`CRSM_DW-1:0]     t2_count,
    input  wire [`CRSM_DW-1:0]     bint_count,
    output reg  [`CRSM_DW-1:0]     rdata,
    output reg                     rvalid,
    output reg  [`CRSM_DW-1:0]     sp_out,
    output reg  [3*`CRSM_DW-1:0]   port_out,
    output reg  [3*`CRSM_DW-1:0]   port_dir,
    output reg  [3*`CRSM_DW-1:0]   port_od,
    output reg  [3*`CRSM_DW-1:0]   port_pu_off,
    output reg  [`CRSM_DW-1:0]     clock_control,
    output reg  [`CRSM_DW-1:0]     watchdog_control,
    output reg  [`CRSM_DW-1:0]     port1_function_select,
    output reg  [`CRSM_DW-1:0]     interrupt_mode,
    output reg  [`CRSM_DW-1:0]     ext_int_edge_select,
    output reg  [4*`CRSM_DW-1:0]   int_regs,
    output reg  [3*`CRSM_DW-1:0]   timer_mode,
    output reg  [`CRSM_DW-1:0]     timer01_combined_mode,
    output reg  [6*`CRSM_DW-1:0]   timer_reload,
    output reg  [`CRSM_DW-1:0]     sleep_control,
    output reg  [2*`CRSM_DW-1:0]   standby_release_select,
    output reg  [2*`CRSM_DW-1:0]   standby_release_level
);
////////////////////////////////////////////////////////////////////////////////
// Decode
    wire                 in_ctl;
    wire                 stack_op;
    wire [`CRSM_AW-1:0]  stack_addr;
    wire [`CRSM_DW-1:0]  sp;
    wire [`CRSM_AW-1:0]  ram_idx;
    wire                 ram_we;
    wire [`CRSM_DW-1:0]  ram_wdata;
    wire [`CRSM_DW-1:0]  ram_rdata;
    wire                 reg_we;
    reg  [`CRSM_DW-1:0]  nxt_rdata;

    assign in_ctl = (addr >= `CRSM_CTL_LO) && (addr <= `CRSM_CTL_HI);
    assign stack_op = push | pop;
    // Stack traffic takes priority over a plain access in the same cycle
    assign ram_idx = stack_op ? stack_addr : addr;
    assign ram_we = push | (req & wr & ~in_ctl & ~stack_op);
    assign ram_wdata = push ? push_data : wdata;
    assign reg_we = req & wr & in_ctl & ~stack_op;

    crsm_stack u_stack (
        .clk        (clk),
        .sp_load    (sp_load),
        .sp_wdata   (wdata),
        .push       (push),
        .pop        (pop),
        .stack_addr (stack_addr),
        .sp         (sp)
    );

    crsm_ram u_ram (
        .clk   (clk),
        .we    (ram_we),
        .idx   (ram_idx),
        .wdata (ram_wdata),
        .rdata (ram_rdata)
    );
////////////////////////////////////////////////////////////////////////////////
// Port data registers: no reset, contents undefined
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_port
            always @(posedge clk) begin
                if (reg_we && addr == `CRSM_A_P0_DATA + 2 * g) begin
                    port_out[g*8 +: 8] <= wdata;
                end
            end
        end
    endgenerate

    // Timer reload data: write-only, undefined at reset
    always @(posedge clk) begin
        if (reg_we) begin
            case (addr)
                `CRSM_A_T0_HM: timer_reload[7:0]   <= wdata;
                `CRSM_A_T0_HL: timer_reload[15:8]  <= wdata;
                `CRSM_A_T0_LM: timer_reload[23:16] <= wdata;
                `CRSM_A_T0_LL: timer_reload[31:24] <= wdata;
                `CRSM_A_T1_H:  timer_reload[39:32] <= wdata;
                `CRSM_A_T2_D:  timer_reload[47:40] <= wdata;
                default: ;
            endcase
        end
    end
////////////////////////////////////////////////////////////////////////////////
// Registers with reset values
    always @(posedge clk) begin
        if (rst) begin
            port_dir               <= {3{`CRSM_RST_ZERO}};
            port_od                <= {3{`CRSM_RST_ZERO}};
            port_pu_off            <= {3{`CRSM_RST_ZERO}};
            clock_control          <= `CRSM_RST_CLK_CTL;
            watchdog_control       <= `CRSM_RST_WDT_CTL;
            port1_function_select  <= `CRSM_RST_ZERO;
            interrupt_mode         <= `CRSM_RST_ZERO;
            ext_int_edge_select    <= `CRSM_RST_ZERO;
            int_regs               <= {4{`CRSM_RST_ZERO}};
            timer_mode             <= {3{`CRSM_RST_ZERO}};
            timer01_combined_mode  <= `CRSM_RST_ZERO;
            sleep_control          <= `CRSM_RST_ZERO;
            standby_release_select <= {2{`CRSM_RST_ZERO}};
            standby_release_level  <= {2{`CRSM_RST_ZERO}};
        end else if (reg_we) begin
            // Reserved addresses fall to default and change nothing
            case (addr)
                `CRSM_A_P0_DIR:    port_dir[7:0]               <= wdata;
                `CRSM_A_P1_DIR:    port_dir[15:8]              <= wdata;
                `CRSM_A_P2_DIR:    port_dir[23:16]             <= wdata;
                `CRSM_A_CLK_CTL:   clock_control               <= wdata;
                `CRSM_A_WDT_CTL:   watchdog_control            <= wdata;
                `CRSM_A_P1_FSEL:   port1_function_select       <= wdata;
                `CRSM_A_INT_MODE:  interrupt_mode              <= wdata;
                `CRSM_A_EDGE_SEL:  ext_int_edge_select         <= wdata;
                `CRSM_A_IEN_LO:    int_regs[7:0]               <= wdata;
                `CRSM_A_IRQ_LO:    int_regs[15:8]              <= wdata;
                `CRSM_A_IEN_HI:    int_regs[23:16]             <= wdata;
                `CRSM_A_IRQ_HI:    int_regs[31:24]             <= wdata;
                `CRSM_A_TM0:       timer_mode[7:0]             <= wdata;
                `CRSM_A_TM1:       timer_mode[15:8]            <= wdata;
                `CRSM_A_TM2:       timer_mode[23:16]           <= wdata;
                `CRSM_A_TIMER01_COMBINED_MODE:      timer01_combined_mode       <= wdata;
                `CRSM_A_SREL_SEL0: standby_release_select[7:0] <= wdata;
                `CRSM_A_SREL_SEL1: standby_release_select[15:8] <= wdata;
                `CRSM_A_P1_OD:     port_od[15:8]               <= wdata;
                `CRSM_A_P2_OD:     port_od[23:16]              <= wdata;
                `CRSM_A_P0_OD:     port_od[7:0]                <= wdata;
                `CRSM_A_SLEEP:     sleep_control               <= wdata;
                `CRSM_A_SREL_LVL0: standby_release_level[7:0]  <= wdata;
                `CRSM_A_SREL_LVL1: standby_release_level[15:8] <= wdata;
                `CRSM_A_P0_PU:     port_pu_off[7:0]            <= wdata;
                `CRSM_A_P1_PU:     port_pu_off[15:8]           <= wdata;
                `CRSM_A_P2_PU:     port_pu_off[23:16]          <= wdata;
                default: ;
            endcase
        end
    end
////////////////////////////////////////////////////////////////////////////////
// Read mux
    // Port reads show the pin when input, the latch when output
    always @* begin
        nxt_rdata = `CRSM_RD_FILL;
        if (pop) begin
            nxt_rdata = ram_rdata;
        end else if (!in_ctl) begin
            nxt_rdata = ram_rdata;
        end else begin
            case (addr)
                `CRSM_A_P0_DATA:   nxt_rdata = (port_dir[7:0] & port_out[7:0])
                                             | (~port_dir[7:0] & p0_pins);
                `CRSM_A_P1_DATA:   nxt_rdata = (port_dir[15:8] & port_out[15:8])
                                             | (~port_dir[15:8] & p1_pins);
                `CRSM_A_P2_DATA:   nxt_rdata = (port_dir[23:16] & port_out[23:16])
                                             | (~port_dir[23:16] & p2_pins);
                `CRSM_A_CLK_CTL:   nxt_rdata = bint_count;
                `CRSM_A_INT_MODE:  nxt_rdata = interrupt_mode;
                `CRSM_A_IEN_LO:    nxt_rdata = int_regs[7:0];
                `CRSM_A_IRQ_LO:    nxt_rdata = int_regs[15:8];
                `CRSM_A_IEN_HI:    nxt_rdata = int_regs[23:16];
                `CRSM_A_IRQ_HI:    nxt_rdata = int_regs[31:24];
                `CRSM_A_TM0:       nxt_rdata = timer_mode[7:0];
                `CRSM_A_TM1:       nxt_rdata = timer_mode[15:8];
                `CRSM_A_TM2:       nxt_rdata = timer_mode[23:16];
                `CRSM_A_T0_LM:     nxt_rdata = t0_hm_count;
                `CRSM_A_T1_L:      nxt_rdata = t1_l_count;
                `CRSM_A_T2_D:      nxt_rdata = t2_count;
                `CRSM_A_TIMER01_COMBINED_MODE:      nxt_rdata = timer01_combined_mode;
                `CRSM_A_SREL_SEL0: nxt_rdata = standby_release_select[7:0];
                `CRSM_A_SREL_SEL1: nxt_rdata = standby_release_select[15:8];
                `CRSM_A_P1_OD:     nxt_rdata = port_od[15:8];
                `CRSM_A_P2_OD:     nxt_rdata = port_od[23:16];
                `CRSM_A_P0_OD:     nxt_rdata = port_od[7:0];
                // Write-only and reserved read as fill, nothing touched
                default:           nxt_rdata = `CRSM_RD_FILL;
            endcase
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            rdata  <= `CRSM_RST_ZERO;
            rvalid <= 1'b0;
        end else begin
            rdata  <= nxt_rdata;
            // A bus read that loses to a stack strobe gets no answer
            rvalid <= (req & ~wr & ~stack_op) | pop;
        end
    end

    // Mirror kept out of reset: the pointer itself is never reset
    always @(posedge clk) begin
        sp_out <= sp;
    end
endmodule
`default_nettype wire

/* hw/crsm_ram.v */
// Purpose: User RAM of flip-flops, byte wide, indexed by address.
// Assumes: Write and read share one index; read is combinational.
// Notes:   Contents are not reset, as real RAM.
`timescale 1ns/100ps
`default_nettype none
`include "crsm_defs.vh"
module crsm_ram (
    input  wire                    clk,
    input  wire                    we,
    input  wire [`CRSM_AW-1:0]     idx,
    input  wire [`CRSM_DW-1:0]     wdata,
    output wire [`CRSM_DW-1:0]     rdata
);
    reg  [`CRSM_DW-1:0] mem_ff [0:`CRSM_RAM_DEPTH-1];
    wire [`CRSM_AW-1:0] row;

    // Page one folds down over the control window gap, so 1FFh stays in range
    assign row = idx[`CRSM_AW-1] ? (idx - `CRSM_RAM_P1_OFS) : idx;

    always @(posedge clk) begin
        if (we) begin
            mem_ff[row] <= wdata;
        end
    end
    assign rdata = mem_ff[row];
endmodule
`default_nettype wire

/* hw/crsm_stack.v */
// Purpose: Stack pointer and push/pop address generation.
// Assumes: One byte saved or restored per strobe.
// Notes:   Pointer has no reset value; software loads it first.
`timescale 1ns/100ps
`default_nettype none
`include "crsm_defs.vh"
module crsm_stack (
    input  wire                    clk,
    input  wire                    sp_load,
    input  wire [`CRSM_DW-1:0]     sp_wdata,
    input  wire                    push,
    input  wire                    pop,
    output wire [`CRSM_AW-1:0]     stack_addr,
    output wire [`CRSM_DW-1:0]     sp
);
    reg  [`CRSM_DW-1:0] sp_ff;
    wire [`CRSM_DW-1:0] sp_inc;

    assign sp_inc = sp_ff + 8'h01;
    // Save at current, restore from pre-incremented location
    assign stack_addr = {`CRSM_STACK_PAGE, (pop ? sp_inc : sp_ff)};
    assign sp = sp_ff;

    // No reset branch on purpose: pointer is undefined after reset
    always @(posedge clk) begin
        if (sp_load) begin
            sp_ff <= sp_wdata;
        end else if (push) begin
            sp_ff <= sp_ff - 8'h01;
        end else if (pop) begin
            sp_ff <= sp_inc;
        end
    end
endmodule
`default_nettype wire

/* shared/crsm_defs.vh */
// Purpose: Address map, reset values and stack constants for the data-memory block.
// Assumes: Byte-wide data bus from the CPU core, 9-bit data address.
// Notes:   Definitions only.
`ifndef CRSM_DEFS_VH
`define CRSM_DEFS_VH

`define CRSM_AW              9
`define CRSM_DW              8
`define CRSM_RAM_DEPTH       448
`define CRSM_CTL_LO          9'h0c0
`define CRSM_CTL_HI          9'h0ff
`define CRSM_STACK_PAGE      1'h1
`define CRSM_RAM_P1_OFS      9'h040

`define CRSM_A_P0_DATA       9'h0c0
`define CRSM_A_P0_DIR        9'h0c1
`define CRSM_A_P1_DATA       9'h0c2
`define CRSM_A_P1_DIR        9'h0c3
`define CRSM_A_P2_DATA       9'h0c4
`define CRSM_A_P2_DIR        9'h0c5
`define CRSM_A_CLK_CTL       9'h0c7
`define CRSM_A_WDT_CTL       9'h0c8
`define CRSM_A_P1_FSEL       9'h0c9
`define CRSM_A_INT_MODE      9'h0ca
`define CRSM_A_EDGE_SEL      9'h0cb
`define CRSM_A_IEN_LO        9'h0cc
`define CRSM_A_IRQ_LO        9'h0cd
`define CRSM_A_IEN_HI        9'h0ce
`define CRSM_A_IRQ_HI        9'h0cf
`define CRSM_A_TM0           9'h0d0
`define CRSM_A_TM1           9'h0d1
`define CRSM_A_TM2           9'h0d2
`define CRSM_A_T0_HM         9'h0d3
`define CRSM_A_T0_HL         9'h0d4
`define CRSM_A_T0_LM         9'h0d5
`define CRSM_A_T0_LL         9'h0d6
`define CRSM_A_T1_H          9'h0d7
`define CRSM_A_T1_L          9'h0d8
`define CRSM_A_T2_D          9'h0d9
`define CRSM_A_TIMER01_COMBINED_MODE          9'h0da
`define CRSM_A_SREL_SEL0     9'h0dc
`define CRSM_A_SREL_SEL1     9'h0dd
`define CRSM_A_P1_OD         9'h0de
`define CRSM_A_P2_OD         9'h0df
`define CRSM_A_P0_OD         9'h0e4
`define CRSM_A_SLEEP         9'h0f0
`define CRSM_A_SREL_LVL0     9'h0f6
`define CRSM_A_SREL_LVL1     9'h0f7
`define CRSM_A_P0_PU         9'h0f8
`define CRSM_A_P1_PU         9'h0f9
`define CRSM_A_P2_PU         9'h0fa

`define CRSM_RST_ZERO        8'h00
`define CRSM_RST_CLK_CTL     8'h37
`define CRSM_RST_WDT_CTL     8'h0f
`define CRSM_RD_FILL         8'h00

`endif

/* verification/crsm_cpu_model.sv */
// Purpose: CPU core model issuing byte accesses and stack strobes.
// Assumes: One operation per call; strobes launched just after a rising edge.
// Notes:   Released address and write data lines show the inverse of the last value.
`timescale 1ns/100ps
`default_nettype none
module crsm_cpu_model (
    input  wire logic       clk,
    output var  logic       req,
    output var  logic       wr,
    output var  logic [8:0] addr,
    output var  logic [7:0] wdata,
    output var  logic       sp_load,
    output var  logic       push,
    output var  logic       pop,
    output var  logic [7:0] push_data,
    input  wire logic [7:0] rdata,
    input  wire logic       rvalid
);
    initial begin
        {req, wr, sp_load, push, pop} = 5'h00;
        {addr, wdata, push_data} = 25'h0000000;
    end
    // Kinds: 0 read, 1 write, 2 pointer load, 3 push, 4 pop
    task automatic op(input int k, input logic [8:0] a, input logic [7:0] d,
                      output logic [8:0] q);
        @(posedge clk);
        req       <= (k < 2);
        wr        <= (k == 1);
        sp_load   <= (k == 2);
        push      <= (k == 3);
        pop       <= (k == 4);
        addr      <= a;
        wdata     <= d;
        push_data <= d;
        @(posedge clk);
        {req, sp_load, push, pop} <= 4'h0;
        addr      <= ~a;
        wdata     <= ~d;
        #1 q = {rvalid, rdata};
    endtask
endmodule
`default_nettype wire

/* verification/crsm_map_props.sv */
// Purpose: Port-level checks of the data-memory map block.
// Assumes: Single clock, synchronous active-high reset.
// Notes:   Stack pointer output lags the pointer by one cycle.
`timescale 1ns/100ps
`default_nettype none
module crsm_map_props (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        req,
    input  wire logic        wr,
    input  wire logic [8:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        sp_load,
    input  wire logic        push,
    input  wire logic        pop,
    input  wire logic [7:0]  rdata,
    input  wire logic        rvalid,
    input  wire logic [7:0]  sp_out,
    input  wire logic [23:0] port_dir,
    input  wire logic [31:0] int_regs,
    input  wire logic [7:0]  watchdog_control,
    input  wire logic [7:0]  interrupt_mode,
    input  wire logic [7:0]  clock_control
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Stack strobes win over a bus request
    wire rd = req & ~wr & ~push & ~pop;
    wire wt = req & wr & ~push & ~pop;
    chk_read_answer: assert property ((rd || pop) |=> rvalid)
        else $error("read without answer");
    chk_idle_quiet: assert property ((!rd && !pop) |=> !rvalid)
        else $error("answer without read");
    chk_wdt_write: assert property (wt && addr == 9'h0c8 |=>
        watchdog_control == $past(wdata))
        else $error("watchdog write lost");
    chk_dir_hold: assert property (!(wt && addr == 9'h0c1) |=> $stable(port_dir[7:0]))
        else $error("direction changed without write");
    chk_wo_read: assert property (rd && addr == 9'h0c1 |=> rdata == 8'h00)
        else $error("write-only read not filled");
    chk_imode_read: assert property (rd && addr == 9'h0ca |=>
        rvalid && rdata == interrupt_mode)
        else $error("mode register read wrong");
    chk_reserved_write: assert property (wt && (addr == 9'h0c6 || addr == 9'h0db)
        |=> $stable(int_regs) && $stable(watchdog_control))
        else $error("reserved write changed state");
    chk_reset_load: assert property ($fell(rst) |-> clock_control == 8'h37 &&
        watchdog_control == 8'h0f && port_dir == 24'h000000 && int_regs == 32'h00000000)
        else $error("reset values wrong");
    chk_push_step: assert property (push && !pop |->
        ##2 sp_out == $past(sp_out) - 8'h01)
        else $error("pointer not decremented");
    chk_pop_step: assert property (pop && !push |->
        ##2 sp_out == $past(sp_out) + 8'h01)
        else $error("pointer not incremented");
    chk_sp_load: assert property (sp_load && !push && !pop |->
        ##2 sp_out == $past(wdata, 2))
        else $error("pointer load lost");
    cover property (wt && addr == 9'h0c8);
    cover property (rd && addr == 9'h0c1);
    cover property (push ##2 push);
endmodule
bind crsm_map crsm_map_props u_props (.clk(clk), .rst(rst), .req(req), .wr(wr), .addr(addr),
    .wdata(wdata), .sp_load(sp_load), .push(push), .pop(pop), .rdata(rdata),
    .rvalid(rvalid), .sp_out(sp_out), .port_dir(port_dir), .int_regs(int_regs),
    .watchdog_control(watchdog_control), .interrupt_mode(interrupt_mode),
    .clock_control(clock_control));
`default_nettype wire

/* verification/tb_top.sv */
// Purpose: Self-checking bench for the data-memory map block.
// Assumes: CPU model drives accesses; pins and counts held by the bench.
// Notes:   Fixed seed; expectations from local tables.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic         clk;
    logic         rst;
    wire          req, wr, sp_load, push, pop, rvalid;
    wire  [8:0]   addr;
    wire  [7:0]   wdata, push_data, rdata, sp_out, clock_control, watchdog_control;
    wire  [7:0]   port1_function_select, interrupt_mode, ext_int_edge_select;
    wire  [7:0]   timer01_combined_mode, sleep_control;
    wire  [15:0]  standby_release_select, standby_release_level;
    wire  [23:0]  port_out, port_dir, port_od, port_pu_off, timer_mode;
    wire  [31:0]  int_regs;
    wire  [47:0]  timer_reload;
    wire  [263:0] outs;
    logic [263:0] snap;
    logic [7:0]   pins [3];
    logic [7:0]   cnt [4];
    logic [8:0]   ra [8];
    logic [7:0]   rv [8];
    logic [8:0]   q;
    logic [7:0]   v, d;
    int           err_total, tests_run, cycles, seed, i, k;
    // Output byte j belongs to address ADR[j]
    localparam logic [8:0] ADR [33] = '{9'h0f0, 9'h0da, 9'h0cb, 9'h0ca, 9'h0c9, 9'h0c8,
        9'h0c7, 9'h0f6, 9'h0f7, 9'h0dc, 9'h0dd, 9'h0d3, 9'h0d4, 9'h0d5, 9'h0d6, 9'h0d7,
        9'h0d9, 9'h0d0, 9'h0d1, 9'h0d2, 9'h0cc, 9'h0cd, 9'h0ce, 9'h0cf, 9'h0f8, 9'h0f9,
        9'h0fa, 9'h0e4, 9'h0de, 9'h0df, 9'h0c1, 9'h0c3, 9'h0c5};
    localparam logic [32:0] RW = 33'h038fe060a;
    localparam logic [8:0] RSV [5] = '{9'h0c6, 9'h0db, 9'h0e0, 9'h0f5, 9'h0ff};
    assign outs = {port_dir, port_od, port_pu_off, int_regs, timer_mode, timer_reload,
        standby_release_select, standby_release_level, clock_control, watchdog_control,
        port1_function_select, interrupt_mode, ext_int_edge_select, timer01_combined_mode,
        sleep_control};
    crsm_cpu_model cpu (.clk(clk), .req(req), .wr(wr), .addr(addr), .wdata(wdata),
        .sp_load(sp_load), .push(push), .pop(pop), .push_data(push_data), .rdata(rdata),
        .rvalid(rvalid));
    crsm_map dut (.clk(clk), .rst(rst), .req(req), .wr(wr), .addr(addr), .wdata(wdata),
        .sp_load(sp_load), .push(push), .pop(pop), .push_data(push_data),
        .p0_pins(pins[0]), .p1_pins(pins[1]), .p2_pins(pins[2]), .t0_hm_count(cnt[0]),
        .t1_l_count(cnt[1]), .t2_count(cnt[2]), .bint_count(cnt[3]), .rdata(rdata),
        .rvalid(rvalid), .sp_out(sp_out), .port_out(port_out), .port_dir(port_dir),
        .port_od(port_od), .port_pu_off(port_pu_off), .clock_control(clock_control),
        .watchdog_control(watchdog_control), .port1_function_select(port1_function_select),
        .interrupt_mode(interrupt_mode), .ext_int_edge_select(ext_int_edge_select),
        .int_regs(int_regs), .timer_mode(timer_mode), .timer_reload(timer_reload),
        .timer01_combined_mode(timer01_combined_mode), .sleep_control(sleep_control),
        .standby_release_select(standby_release_select),
        .standby_release_level(standby_release_level));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rdx(input int j, input logic [7:0] w);
        if (RW[j]) return w;
        case (ADR[j])
            9'h0c7:  return cnt[3];
            9'h0d5:  return cnt[0];
            9'h0d9:  return cnt[2];
            default: return 8'h00;
        endcase
    endfunction
    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rst_chk();
        // Reload bytes have no reset value, so skipped
        for (k = 0; k < 33; k++) begin
            v = (k == 6) ? 8'h37 : (k == 5) ? 8'h0f : 8'h00;
            if (k < 11 || k > 16)
                chk("reset value", {1'b0, v}, {1'b0, outs[8*k +: 8]});
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            conclude();
        end
    end
    initial begin
        rst = 1'b1;
        seed = 32'h0c5c1757;
        for (k = 0; k < 3; k++) pins[k] = 8'h00;
        for (k = 0; k < 4; k++) cnt[k] = 8'h00;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (k = 0; k < 4; k++) cnt[k] <= 8'($random(seed));
        for (k = 0; k < 3; k++) pins[k] <= 8'($random(seed));
        @(posedge clk);
        #1 rst_chk();
        for (i = 0; i < 33; i++) begin
            v = 8'($random(seed));
            cpu.op(1, ADR[i], v, q);
            chk("register output", {1'b0, v}, {1'b0, outs[8*i +: 8]});
            cpu.op(0, ADR[i], 8'h00, q);
            chk("register read", {1'b1, rdx(i, v)}, q);
            chk("read side effect", {1'b0, v}, {1'b0, outs[8*i +: 8]});
        end
        for (i = 0; i < 5; i++) begin
            snap = outs;
            cpu.op(1, RSV[i], 8'($random(seed)), q);
            cpu.op(0, RSV[i], 8'h00, q);
            chk("reserved read", 9'h100, q);
            chk("reserved write", 9'h000, {8'h00, outs !== snap});
        end
        cpu.op(0, 9'h0d8, 8'h00, q);
        chk("timer1 count", {1'b1, cnt[1]}, q);
        for (i = 0; i < 3; i++) begin
            d = 8'($random(seed));
            v = 8'($random(seed));
            cpu.op(1, 9'h0c1 + 9'(2 * i), d, q);
            cpu.op(1, 9'h0c0 + 9'(2 * i), v, q);
            cpu.op(0, 9'h0c0 + 9'(2 * i), 8'h00, q);
            chk("port read", {1'b1, (v & d) | (pins[i] & ~d)}, q);
            chk("port latch", {1'b0, v}, {1'b0, port_out[8*i +: 8]});
        end
        // Alternate low area and page one, top byte of page one included
        for (i = 0; i < 8; i++) begin
            ra[i] = 9'(i * 24 + {$random(seed)} % 24 + (i % 2) * 256);
            if (i == 7) ra[i] = 9'h1ff;
            rv[i] = 8'($random(seed));
            cpu.op(1, ra[i], rv[i], q);
        end
        for (i = 0; i < 8; i++) begin
            cpu.op(0, ra[i], 8'h00, q);
            chk("ram", {1'b1, rv[i]}, q);
        end
        cpu.op(2, 9'h000, 8'hff, q);
        for (i = 0; i < 3; i++) begin
            rv[i] = 8'($random(seed));
            cpu.op(3, 9'h000, rv[i], q);
        end
        @(posedge clk);
        #1 chk("sp after push", 9'h0fc, {1'b0, sp_out});
        cpu.op(0, 9'h1ff, 8'h00, q);
        chk("stack slot", {1'b1, rv[0]}, q);
        for (i = 2; i >= 0; i--) begin
            cpu.op(4, 9'h000, 8'h00, q);
            chk("stack restore", {1'b1, rv[i]}, q);
        end
        @(posedge clk);
        #1 chk("sp after pop", 9'h0ff, {1'b0, sp_out});
        cpu.op(1, 9'h0c8, 8'h5a, q);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 rst_chk();
        chk("sp kept", 9'h0ff, {1'b0, sp_out});
        conclude();
    end
endmodule
`default_nettype wire
